/* File: rtl/hci_map.vh */
// Constants for the host command interface: timing, codes, bit fields.
// Assumes a 50 MHz core clock; included by hci_top.
`ifndef HCI_MAP_VH
`define HCI_MAP_VH
// ==========================================================
// Timing
`define HCI_CLK_NS       20
`define HCI_WAKE_MIN_NS  10000
`define HCI_SETTLE_US    2000
`define HCI_UART_DEF_CYC 16'h0364
`define HCI_UART_MIN_CYC 16'h0019
// ==========================================================
// Straps {high, low}
`define HCI_STRAP_SPI    2'h1
`define HCI_STRAP_UART   2'h0
// ==========================================================
// SPI control byte operations
`define HCI_CTL_SEND     2'h0
`define HCI_CTL_POLL     2'h3
`define HCI_CTL_READ     2'h2
`define HCI_CTL_RESET    2'h1
// ==========================================================
// Flag byte bit positions
`define HCI_FLAG_RSP     3
`define HCI_FLAG_CMD     2
// ==========================================================
// Command codes
`define HCI_CODE_ECHO    8'h55
`define HCI_CODE_LO      8'h01
`define HCI_CODE_HI      8'h07
`define HCI_CODE_RATE    8'h0a
`define HCI_CODE_SUBC    8'h0b
`define HCI_CODE_ACF     8'h0d
`endif

/* File: rtl/hci_buf2.v */
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides on the same clock and a synchronous reset.
`timescale 1ns/10ps
module hci_buf2 #(
    parameter W = 11
) (
    // Clock and reset
    input  wire         mclk_i,
    input  wire         reset_i,
    // Filling side
    input  wire         in_valid_i,
    output wire         in_ready_o,
    input  wire [W-1:0] in_data_i,
    // Draining side
    output wire         out_valid_o,
    input  wire         out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem [0:1];
    reg         wp;
    reg         rp;
    reg [1:0]   cnt;
    wire        push;
    wire        pop;

    // Handshakes from the fill count
    assign in_ready_o  = (cnt != 2'h2);
    assign out_valid_o = (cnt != 2'h0);
    assign out_data_o  = mem[rp];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointers and fill count
    always @(posedge mclk_i) begin
        if (reset_i) begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'h0;
        end else begin
            if (push) begin
                wp <= ~wp;
            end
            if (pop) begin
                rp <= ~rp;
            end
            if (push & ~pop) begin
                cnt <= cnt + 2'h1;
            end else if (pop & ~push) begin
                cnt <= cnt - 2'h1;
            end
        end
    end

    // Storage has no reset; guarded by cnt
    always @(posedge mclk_i) begin
        if (push) begin
            mem[wp] <= in_data_i;
        end
    end
endmodule // hci_buf2

/* File: rtl/hci_top.v */
// Host command interface: wake-up, strap selection, SPI and UART ports,
// command frame parsing and response return.
// Assumes pins are asynchronous to mclk_i; core logic shares mclk_i.
`timescale 1ns/10ps
`include "hci_map.vh"
module hci_top #(
    parameter SETTLE_CYC = `HCI_SETTLE_US * 1000 / `HCI_CLK_NS
) (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        reset_i,
    // Straps and wake / UART receive line
    input  wire        interface_strap_low_i,
    input  wire        interface_strap_high_i,
    input  wire        wake_rx_n_i,
    // SPI pins
    input  wire        spi_chip_select_n_i,
    input  wire        spi_sck_i,
    input  wire        spi_mosi_i,
    output reg         spi_miso_o,
    output reg         spi_miso_oe_o,
    output reg         reply_irq_n_o,
    // UART transmit pin
    output reg         uart_tx_o,
    // Core control and status
    input  wire [15:0] uart_bit_cyc_i,
    input  wire        sleep_i,
    input  wire        hibernate_i,
    output reg         ready_o,
    output reg         spi_selected_o,
    output reg         uart_selected_o,
    output reg         device_reset_o,
    // Command byte stream to core
    output wire [7:0]  cmd_data_o,
    output wire        cmd_first_o,
    output wire        cmd_last_o,
    output wire        cmd_reserved_o,
    output wire        cmd_valid_o,
    input  wire        cmd_ready_i,
    // Response byte stream from core
    input  wire [7:0]  rsp_data_i,
    input  wire        rsp_valid_i,
    output wire        rsp_ready_o
);
    localparam WAKE_CYC = (`HCI_WAKE_MIN_NS + `HCI_CLK_NS - 1) / `HCI_CLK_NS;
    localparam W_OFF = 2'h0, W_LOW = 2'h1, W_SETTLE = 2'h2, W_READY = 2'h3;
    localparam S_CTRL = 3'h0, S_SEND = 3'h1, S_POLL = 3'h2, S_READ = 3'h3;
    localparam S_IGN = 3'h4;
    localparam P_CODE = 2'h0, P_LEN = 2'h1, P_DATA = 2'h2;

    // Defined command code check
    function hci_known;
        input [7:0] c;
        begin
            hci_known = (c >= `HCI_CODE_LO && c <= `HCI_CODE_HI) ||
                        c == `HCI_CODE_RATE || c == `HCI_CODE_SUBC ||
                        c == `HCI_CODE_ACF;
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    reg  [5:0]  sy1;
    reg  [5:0]  sy2;
    reg         sck_d;
    reg         wake_d;
    wire        strap_hi = sy2[5];
    wire        strap_lo = sy2[4];
    wire        wake_n   = sy2[3];
    wire        cs_n     = sy2[2];
    wire        sck      = sy2[1];
    wire        mosi     = sy2[0];

    // Two flops per pin, then edge history; SCK to 2 Mbit/s
    always @(posedge mclk_i) begin
        if (reset_i) begin
            sy1    <= 6'h3f;
            sy2    <= 6'h3f;
            sck_d  <= 1'b1;
            wake_d <= 1'b1;
        end else begin
            sy1    <= {interface_strap_high_i, interface_strap_low_i,
                       wake_rx_n_i, spi_chip_select_n_i, spi_sck_i,
                       spi_mosi_i};
            sy2    <= sy1;
            sck_d  <= sck;
            wake_d <= wake_n;
        end
    end

    // ==========================================================
    // Wake-up and interface selection
    reg  [1:0]  wstate;
    reg  [16:0] wcnt;
    reg         latched;
    wire        wake_fall = wake_d & ~wake_n;

    always @(posedge mclk_i) begin
        if (reset_i) begin
            wstate          <= W_OFF;
            wcnt            <= 17'h0;
            latched         <= 1'b0;
            ready_o         <= 1'b0;
            spi_selected_o  <= 1'b0;
            uart_selected_o <= 1'b0;
        end else begin
            case (wstate)
                W_OFF: begin
                    ready_o <= 1'b0;
                    wcnt    <= 17'h0;
                    if (wake_fall) begin
                        wstate <= W_LOW;
                        if (!latched) begin
                            latched <= 1'b1;
                            spi_selected_o <= ({strap_hi, strap_lo} ==
                                               `HCI_STRAP_SPI);
                            uart_selected_o <= ({strap_hi, strap_lo} ==
                                                `HCI_STRAP_UART);
                        end
                    end
                end
                W_LOW: begin
                    if (wake_n) begin
                        // Short pulses are ignored
                        wcnt   <= 17'h0;
                        wstate <= (wcnt >= WAKE_CYC) ? W_SETTLE : W_OFF;
                    end else if (wcnt < WAKE_CYC) begin
                        wcnt <= wcnt + 17'h1;
                    end
                end
                W_SETTLE: begin
                    if (wcnt >= SETTLE_CYC - 1) begin
                        wstate  <= W_READY;
                        ready_o <= 1'b1;
                    end else begin
                        wcnt <= wcnt + 17'h1;
                    end
                end
                default: begin
                    if (device_reset_o | hibernate_i) begin
                        // Back to power-up: reselect on next wake
                        wstate  <= W_OFF;
                        latched <= 1'b0;
                        ready_o <= 1'b0;
                    end else if (sleep_i) begin
                        wstate  <= W_OFF;
                        ready_o <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Response source and flag byte
    reg         echo_pend;
    reg         tk_s;
    reg         tk_s_e;
    reg         tk_u;
    reg         tk_u_e;
    wire        buf_in_ready;
    wire        rsp_avail = echo_pend | rsp_valid_i;
    wire [7:0]  rsp_byte  = echo_pend ? `HCI_CODE_ECHO : rsp_data_i;
    wire        took_echo = (tk_s & tk_s_e) | (tk_u & tk_u_e);
    reg  [7:0]  flags;

    assign rsp_ready_o = (tk_s & ~tk_s_e) | (tk_u & ~tk_u_e);

    // Flag byte, upper nibble and reserved bits zero
    always @* begin
        flags = 8'h00;
        flags[`HCI_FLAG_RSP] = rsp_avail;
        flags[`HCI_FLAG_CMD] = buf_in_ready;
    end

    // ==========================================================
    // SPI slave
    reg  [2:0]  sstate;
    reg  [2:0]  bitc;
    reg  [7:0]  srx;
    reg  [7:0]  stx;
    reg         tx_hold;
    reg         spi_byte_v;
    reg  [7:0]  spi_byte;
    wire        cs_act   = ~cs_n & ready_o & spi_selected_o;
    wire        sck_rise = ~sck_d & sck;
    wire        sck_fall = sck_d & ~sck;
    wire [7:0]  nb       = {srx[6:0], mosi};

    always @(posedge mclk_i) begin
        if (reset_i) begin
            sstate         <= S_CTRL;
            bitc           <= 3'h0;
            srx            <= 8'h00;
            stx            <= 8'h00;
            tx_hold        <= 1'b0;
            spi_byte_v     <= 1'b0;
            spi_byte       <= 8'h00;
            spi_miso_o     <= 1'b0;
            spi_miso_oe_o  <= 1'b0;
            device_reset_o <= 1'b0;
            tk_s           <= 1'b0;
            tk_s_e         <= 1'b0;
        end else begin
            spi_byte_v     <= 1'b0;
            device_reset_o <= 1'b0;
            tk_s           <= 1'b0;
            spi_miso_o     <= stx[7];
            if (!cs_act) begin
                // Deselected: drop bits, release output
                sstate        <= S_CTRL;
                bitc          <= 3'h0;
                stx           <= 8'h00;
                tx_hold       <= 1'b0;
                spi_miso_oe_o <= 1'b0;
            end else begin
                spi_miso_oe_o <= 1'b1;
                if (sck_rise) begin
                    // Sample on rising edge, MSB first
                    srx  <= nb;
                    bitc <= bitc + 3'h1;
                    if (bitc == 3'h7) begin
                        case (sstate)
                            S_CTRL: begin
                                case (nb[1:0])
                                    `HCI_CTL_SEND: sstate <= S_SEND;
                                    `HCI_CTL_POLL: begin
                                        sstate  <= S_POLL;
                                        stx     <= flags;
                                        tx_hold <= 1'b1;
                                    end
                                    `HCI_CTL_READ: begin
                                        sstate  <= S_READ;
                                        stx     <= rsp_avail ? rsp_byte
                                                             : 8'h00;
                                        tx_hold <= 1'b1;
                                        tk_s    <= rsp_avail;
                                        tk_s_e  <= echo_pend;
                                    end
                                    default: begin
                                        sstate         <= S_IGN;
                                        device_reset_o <= 1'b1;
                                    end
                                endcase
                            end
                            S_SEND: begin
                                spi_byte_v <= 1'b1;
                                spi_byte   <= nb;
                            end
                            S_POLL: begin
                                // Fresh flags every byte
                                stx     <= flags;
                                tx_hold <= 1'b1;
                            end
                            S_READ: begin
                                stx     <= rsp_avail ? rsp_byte : 8'h00;
                                tx_hold <= 1'b1;
                                tk_s    <= rsp_avail;
                                tk_s_e  <= echo_pend;
                            end
                            default: sstate <= S_IGN;
                        endcase
                    end
                end else if (sck_fall) begin
                    // Next bit out on the falling edge
                    if (tx_hold) begin
                        tx_hold <= 1'b0;
                    end else begin
                        stx <= {stx[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // ==========================================================
    // UART receive and transmit, LSB first
    reg  [15:0] rcnt;
    reg  [3:0]  rbit;
    reg         rbusy;
    reg  [7:0]  rsr;
    reg         uart_byte_v;
    reg  [15:0] tcnt;
    reg  [3:0]  tbit;
    reg  [8:0]  tsr;
    wire        u_act = ready_o & uart_selected_o;
    wire [15:0] bcyc;

    // Rate clamped to the 2 Mbit/s ceiling
    assign bcyc = (uart_bit_cyc_i < `HCI_UART_MIN_CYC) ? `HCI_UART_MIN_CYC
                                                       : uart_bit_cyc_i;

    // Receiver only runs once ready, so the wake pulse is ignored
    always @(posedge mclk_i) begin
        if (reset_i | ~u_act) begin
            rcnt        <= 16'h0;
            rbit        <= 4'h0;
            rbusy       <= 1'b0;
            rsr         <= 8'h00;
            uart_byte_v <= 1'b0;
        end else begin
            uart_byte_v <= 1'b0;
            if (!rbusy) begin
                if (wake_fall) begin
                    rbusy <= 1'b1;
                    rbit  <= 4'h0;
                    rcnt  <= {1'b0, bcyc[15:1]};
                end
            end else if (rcnt != 16'h0) begin
                rcnt <= rcnt - 16'h1;
            end else begin
                rcnt <= bcyc - 16'h1;
                rbit <= rbit + 4'h1;
                if (rbit == 4'h0) begin
                    rbusy <= ~wake_n;
                end else if (rbit == 4'h9) begin
                    rbusy       <= 1'b0;
                    uart_byte_v <= wake_n;
                end else begin
                    rsr <= {wake_n, rsr[7:1]};
                end
            end
        end
    end

    // Transmitter drains the response stream
    always @(posedge mclk_i) begin
        if (reset_i | ~u_act) begin
            tcnt      <= 16'h0;
            tbit      <= 4'h0;
            tsr       <= 9'h1ff;
            uart_tx_o <= 1'b1;
            tk_u      <= 1'b0;
            tk_u_e    <= 1'b0;
        end else begin
            tk_u <= 1'b0;
            if (tcnt != 16'h0) begin
                // Counting here also times the stop bit before a reload
                tcnt <= tcnt - 16'h1;
            end else if (tbit == 4'h0) begin
                if (rsp_avail & ~tk_u) begin
                    tsr       <= {rsp_byte, 1'b0};
                    tbit      <= 4'ha;
                    tcnt      <= 16'h0;
                    tk_u      <= 1'b1;
                    tk_u_e    <= echo_pend;
                end
            end else begin
                uart_tx_o <= tsr[0];
                tsr       <= {1'b1, tsr[8:1]};
                tcnt      <= bcyc - 16'h1;
                tbit      <= tbit - 4'h1;
            end
        end
    end

    // ==========================================================
    // Command frame parser feeding the buffer
    reg  [1:0]  pstate;
    reg  [7:0]  remain;
    reg         reserved;
    reg  [10:0] pin;
    reg         pin_v;
    wire        in_v = spi_byte_v | uart_byte_v;
    wire [7:0]  in_b = spi_selected_o ? spi_byte : rsr;

    always @(posedge mclk_i) begin
        if (reset_i | ~ready_o) begin
            pstate    <= P_CODE;
            remain    <= 8'h00;
            reserved  <= 1'b0;
            pin       <= 11'h000;
            pin_v     <= 1'b0;
            echo_pend <= 1'b0;
        end else begin
            if (in_v && pstate == P_CODE && in_b == `HCI_CODE_ECHO) begin
                echo_pend <= 1'b1;
            end else if (took_echo) begin
                echo_pend <= 1'b0;
            end
            if (pin_v & buf_in_ready) begin
                pin_v <= 1'b0;
            end
            if (in_v) begin
                case (pstate)
                    P_CODE: begin
                        if (in_b != `HCI_CODE_ECHO) begin
                            reserved <= ~hci_known(in_b);
                            pin      <= {~hci_known(in_b), 2'h2, in_b};
                            pin_v    <= 1'b1;
                            pstate   <= P_LEN;
                        end
                    end
                    P_LEN: begin
                        remain <= in_b;
                        pin    <= {reserved, 1'b0, (in_b == 8'h00), in_b};
                        pin_v  <= 1'b1;
                        pstate <= (in_b == 8'h00) ? P_CODE : P_DATA;
                    end
                    default: begin
                        remain <= remain - 8'h01;
                        pin    <= {reserved, 1'b0, (remain == 8'h01), in_b};
                        pin_v  <= 1'b1;
                        if (remain == 8'h01) begin
                            pstate <= P_CODE;
                        end
                    end
                endcase
            end
        end
    end

    // Reply interrupt for SPI hosts
    always @(posedge mclk_i) begin
        if (reset_i) begin
            reply_irq_n_o <= 1'b1;
        end else begin
            reply_irq_n_o <= ~(ready_o & spi_selected_o & rsp_avail);
        end
    end

    // Buffer between parser and core
    hci_buf2 #(
        .W (11)
    ) u_buf (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .in_valid_i  (pin_v),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (pin),
        .out_valid_o (cmd_valid_o),
        .out_ready_i (cmd_ready_i),
        .out_data_o  ({cmd_reserved_o, cmd_first_o, cmd_last_o, cmd_data_o})
    );
endmodule // hci_top

/* File: dv/hci_sva.sv */
// Checker for the host command interface top-level ports.
// Assumes a bind onto hci_top; one clock domain on mclk_i.
`timescale 1ns/10ps
module hci_sva (
    // Clock and reset
    input logic       mclk_i,
    input logic       reset_i,
    // Pins
    input logic       wake_rx_n_i,
    input logic       spi_chip_select_n_i,
    input logic       spi_miso_oe_o,
    input logic       reply_irq_n_o,
    input logic       uart_tx_o,
    // Status
    input logic       ready_o,
    input logic       spi_selected_o,
    input logic       uart_selected_o,
    input logic       device_reset_o,
    // Command stream
    input logic [7:0] cmd_data_o,
    input logic       cmd_valid_o,
    input logic       cmd_ready_i
);
    // ==========================================================
    // Properties
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    property p_oe_cs;
        spi_chip_select_n_i [*4] |-> !spi_miso_oe_o;
    endproperty
    a_oe_cs: assert property (p_oe_cs)
        else $error("data out driven while deselected");
    property p_oe_rdy;
        !ready_o [*3] |-> !spi_miso_oe_o;
    endproperty
    a_oe_rdy: assert property (p_oe_rdy)
        else $error("data out driven before ready");
    property p_irq;
        !reply_irq_n_o |-> spi_selected_o && (ready_o || $past(ready_o));
    endproperty
    a_irq: assert property (p_irq)
        else $error("reply interrupt outside ready SPI mode");
    property p_tx_idle;
        !uart_selected_o |-> uart_tx_o;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("transmit line active without UART");
    property p_excl;
        !(spi_selected_o && uart_selected_o);
    endproperty
    a_excl: assert property (p_excl)
        else $error("both ports selected");
    property p_sel_hold;
        ready_o && $past(ready_o) |-> $stable(spi_selected_o);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("port choice changed while ready");
    property p_ready;
        !ready_o ##1 ready_o |-> $past(wake_rx_n_i, 4);
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready rose while wake still low");
    property p_rst;
        device_reset_o |=> !device_reset_o ##[0:2] !ready_o;
    endproperty
    a_rst: assert property (p_rst)
        else $error("device reset not a pulse or ready kept");
    property p_cmd_hold;
        cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_data_o);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command byte lost under stall");
endmodule // hci_sva

/* File: dv/hci_host.sv */
// Host model: wake pulse, mode 0 SPI bytes, no clock recovery
// Assumes the bench calls its tasks; SCK stands low between frames.
`timescale 1ns/10ps
module hci_host (
    // Clock
    input  logic mclk_i,
    // Pins toward the device
    output logic wake_n_o,
    output logic cs_n_o,
    output logic sck_o,
    output logic mosi_o,
    // Returned data
    input  logic miso_i,
    input  logic miso_oe_i
);
    // ==========================================================
    // Line state; a released line shows the inverse of its last level
    logic last = 1'b0;
    wire  line = miso_oe_i ? miso_i : ~last;
    initial begin
        wake_n_o = 1'b1;
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    // Low pulse on the wake line for n cycles
    task automatic wake(input int n);
        @(posedge mclk_i) wake_n_o <= 1'b0;
        repeat (n) @(posedge mclk_i);
        wake_n_o <= 1'b1;
    endtask
    // Chip select framing, raised between transactions
    task automatic sel(input logic on);
        repeat (4) @(posedge mclk_i);
        cs_n_o <= ~on;
        if (!on) mosi_o <= ~mosi_o;
        repeat (8) @(posedge mclk_i);
    endtask
    // One byte each way, MSB first, 160 ns SCK period
    task automatic xfer(input [7:0] t, output [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            mosi_o <= t[i];
            repeat (4) @(posedge mclk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge mclk_i);
            // Sample late in the high phase, before the device shifts
            r[i] = line;
            last <= line;
            sck_o <= 1'b0;
        end
    endtask
endmodule // hci_host

/* File: dv/tb.sv */
// Self-checking bench for the host command interface over SPI.
// Assumes hci_top, hci_host and hci_sva are compiled before it.
`timescale 1ns/10ps
`define CHK(g, e) check_val(16'(g), 16'(e))
module tb;
    // ==========================================================
    // Signals
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        strap_lo = 1'b1;
    logic        cmd_ready = 1'b1;
    logic        rsp_go = 1'b0, rsp_v = 1'b0, rst_seen = 1'b0;
    logic [7:0]  rsp_d = 8'h00;
    wire         uart_tx, dev_rst, rsp_rdy;
    wire         wake_n, cs_n, sck, mosi, miso, oe, irq_n, ready;
    wire         spi_sel, uart_sel, cmd_first, cmd_last, cmd_res, cmd_valid;
    wire  [7:0]  cmd_data;
    logic [10:0] q[$];
    logic [7:0]  r;
    int          fail_count = 0;
    int          checked = 0;
    always #10 mclk_i = ~mclk_i;
    hci_top #(.SETTLE_CYC(50)) uut (
        .mclk_i(mclk_i), .reset_i(reset_i),
        .interface_strap_low_i(strap_lo), .interface_strap_high_i(1'b0),
        .wake_rx_n_i(wake_n), .spi_chip_select_n_i(cs_n),
        .spi_sck_i(sck), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(oe), .reply_irq_n_o(irq_n), .uart_tx_o(uart_tx),
        .uart_bit_cyc_i(16'h0364), .sleep_i(1'b0), .hibernate_i(1'b0),
        .ready_o(ready), .spi_selected_o(spi_sel),
        .uart_selected_o(uart_sel), .device_reset_o(dev_rst),
        .cmd_data_o(cmd_data), .cmd_first_o(cmd_first),
        .cmd_last_o(cmd_last), .cmd_reserved_o(cmd_res),
        .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready),
        .rsp_data_i(rsp_d), .rsp_valid_i(rsp_v), .rsp_ready_o(rsp_rdy));
    hci_host host (.mclk_i(mclk_i), .wake_n_o(wake_n), .cs_n_o(cs_n),
        .sck_o(sck), .mosi_o(mosi), .miso_i(miso), .miso_oe_i(oe));
    // Command stream capture: {reserved code, first, last, data}
    always @(posedge mclk_i)
        if (cmd_valid && cmd_ready)
            q.push_back({cmd_first & cmd_res, cmd_first, cmd_last, cmd_data});
    // Core model: response held until taken; reset pulse seen
    always @(posedge mclk_i) begin
        rsp_v <= rsp_v ? !rsp_rdy : rsp_go;
        if (dev_rst) rst_seen <= 1'b1;
    end
    // ==========================================================
    // Helpers
    task automatic check_val(input [15:0] g, e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Bounded wait on ready (irq=0) or the reply interrupt (irq=1)
    task automatic wait_for(input bit irq, input logic v);
        int n;
        for (n = 0; n < 2000 && (irq ? irq_n : ready) !== v; n++)
            @(posedge mclk_i);
        if (n == 2000) begin
            fail_count++;
            give_verdict();
        end
    endtask
    // One framed transaction of n bytes; r keeps the last byte read
    task automatic tx(input [31:0] w, input int n);
        host.sel(1'b1);
        for (int k = 0; k < n; k++)
            host.xfer(w[8*(3-k) +: 8], r);
        host.sel(1'b0);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_wake;
        repeat (5000) @(posedge mclk_i);
        host.wake(100);
        repeat (300) @(posedge mclk_i);
        `CHK(ready, 1'b0);
        host.wake(600);
        wait_for(1'b0, 1'b1);
        `CHK(spi_sel, 1'b1);
        strap_lo <= 1'b0;
        repeat (10) @(posedge mclk_i);
        `CHK({spi_sel, uart_sel}, 2'h2);
        $display("test wake done");
    endtask
    task automatic t_poll;
        `CHK(oe, 1'b0);
        tx(32'h03ffff00, 3);
        `CHK(r, 8'h04);
        $display("test poll done");
    endtask
    task automatic t_frame;
        q.delete();
        tx(32'h000801a5, 4);
        @(posedge mclk_i) cmd_ready <= 1'b0;
        tx(32'h00030000, 3);
        `CHK(q.size(), 3);
        `CHK(cmd_valid, 1'b1);
        cmd_ready <= 1'b1;
        repeat (5) @(posedge mclk_i);
        `CHK(q.size(), 5);
        foreach (q[i])
            `CHK(q[i], i == 0 ? 11'h608 : i == 1 ? 11'h001 :
                i == 2 ? 11'h1a5 : i == 3 ? 11'h203 : 11'h100);
        $display("test frame done");
    endtask
    task automatic t_echo;
        q.delete();
        tx(32'h00550000, 2);
        wait_for(1'b1, 1'b0);
        tx(32'h03ff0000, 2);
        `CHK(r, 8'h0c);
        tx(32'h02ff0000, 2);
        `CHK(r, 8'h55);
        `CHK(q.size(), 0);
        rsp_d <= 8'h3a;
        rsp_go <= 1'b1;
        @(posedge mclk_i) rsp_go <= 1'b0;
        wait_for(1'b1, 1'b0);
        tx(32'h02ff0000, 2);
        `CHK(r, 8'h3a);
        `CHK(rsp_v, 1'b0);
        repeat (20) @(posedge mclk_i);
        `CHK(irq_n, 1'b1);
        $display("test echo done");
    endtask
    task automatic t_reset;
        tx(32'h01000000, 1);
        `CHK(ready, 1'b0);
        host.wake(600);
        wait_for(1'b0, 1'b1);
        `CHK(ready, 1'b1);
        `CHK(rst_seen, 1'b1);
        `CHK({uart_sel, uart_tx}, 2'h3);
        $display("test reset done");
    endtask
    initial begin
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_wake();
        t_poll();
        t_frame();
        t_echo();
        t_reset();
        give_verdict();
    end
endmodule // tb
bind hci_top hci_sva u_sva (.mclk_i(mclk_i), .reset_i(reset_i),
    .wake_rx_n_i(wake_rx_n_i), .spi_chip_select_n_i(spi_chip_select_n_i),
    .spi_miso_oe_o(spi_miso_oe_o), .reply_irq_n_o(reply_irq_n_o),
    .uart_tx_o(uart_tx_o), .ready_o(ready_o),
    .spi_selected_o(spi_selected_o), .uart_selected_o(uart_selected_o),
    .device_reset_o(device_reset_o), .cmd_data_o(cmd_data_o),
    .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i));
